// [hw/tmds_pixel_out.sv]
// Purpose: Maps recovered channels to pixel buses and control outputs
// Assumes: link_clk_in is the recovered reference clock, one pixel each
// Notes:   Link activity is watched in both clock domains
//
// Function
// - Channel one: green in display, control one otherwise
// - Channel two: red in display, controls two, three
// - Link-active follows display-flag toggling
// - Stagger honoured only in two-pixel mode
// - Stagger low offsets even and odd outputs
// - Output clock period one or two pixels
// - Deskew channels up to one pixel time
// - Display flag high in display, low blanking
// - Driver powerdown floats outputs except two
// - One-pixel mode sequential on even bus
// - Inactive after 1e6 quiet, active after 1600
`timescale 1ns/1ps
module tmds_pixel_out #(
  parameter int INACTIVE_PIX = tmds_out_pkg::INACTIVE_PIX_DEF
) (
  // System clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      reset_n_in,
  // Recovered link
  input  wire logic                      link_clk_in,
  input  wire tmds_out_pkg::channel_sym_t [tmds_out_pkg::NUM_CH-1:0] sym_in,
  // Mode pins
  input  wire logic                      pixels_per_clock_select_in,
  input  wire logic                      stagger_select_n_in,
  input  wire logic                      output_driver_powerdown_n_in,
  input  wire logic                      chip_powerdown_n_in,
  // Pixel outputs
  output tmds_out_pkg::pixel_t           even_pixel_bus_out,
  output tmds_out_pkg::pixel_t           odd_pixel_bus_out,
  output tmds_out_pkg::ctrl_bits_t       ctrl_bits_out,
  output logic                           active_display_flag_out,
  output logic                           output_pixel_clock_out,
  output logic                           link_active_flag_out,
  // Output enables
  output logic                           drivers_oe_out,
  output logic                           ctl_one_oe_out,
  output logic                           link_active_oe_out
);
  import tmds_out_pkg::*;

  generate
    if (INACTIVE_PIX <= ACTIVE_PIX ||
        INACTIVE_PIX >= (1 << GAP_W)) begin : g_chk
      $error("INACTIVE_PIX out of range for the silence counter");
    end
  endgenerate

  // ****************************************************************
  // Link domain reset and pin synchronisers
  // ****************************************************************
  logic [SYNC_STAGES-1:0] lrst_r;     // Reset release into link domain
  logic [SYNC_STAGES-1:0] pix2_r;     // Pixel-per-clock pin sync
  logic [SYNC_STAGES-1:0] stagger_select_n_r;     // Stagger pin sync
  logic                   lrst_n;
  logic                   pix2;
  logic                   stagger_select_n_n;

  // Assert at once, release on the link clock
  always_ff @(posedge link_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lrst_r <= '0;
    end else begin
      lrst_r <= {lrst_r[0], 1'b1};
    end
  end
  assign lrst_n = lrst_r[SYNC_STAGES-1];

  // Mode pins come from the board, asynchronous to the link
  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      pix2_r <= '0;
      stagger_select_n_r <= '1;
    end else begin
      pix2_r <= {pix2_r[0], pixels_per_clock_select_in};
      stagger_select_n_r <= {stagger_select_n_r[0], stagger_select_n_in};
    end
  end
  assign pix2   = pix2_r[SYNC_STAGES-1];
  assign stagger_select_n_n = stagger_select_n_r[SYNC_STAGES-1] | ~pix2;

  // ****************************************************************
  // Channel alignment and mapping
  // ****************************************************************
  channel_sym_t [NUM_CH-1:0] al;      // Aligned symbols
  pixel_t                    pix;     // Current pixel from three bytes
  ctrl_bits_t                ctl_now; // Current blanking bits
  logic                      de_now;  // All channels carry pixels
  logic                      de_prev_r;
  logic                      de_rise;
  logic                      de_tr;

  channel_deskew #(.NCH(NUM_CH)) u_deskew (
    .clk_in     (link_clk_in),
    .reset_n_in (lrst_n),
    .sym_in     (sym_in),
    .sym_out    (al)
  );

  assign de_now          = al[CH_RED].is_pixel & al[CH_GREEN].is_pixel &
                           al[CH_BLUE].is_pixel;
  assign de_rise         = de_now & ~de_prev_r;
  assign de_tr           = de_now ^ de_prev_r;
  assign pix.red         = al[CH_RED].data;
  assign pix.green       = al[CH_GREEN].data;
  assign pix.blue        = al[CH_BLUE].data;
  assign ctl_now.hsync   = al[CH_BLUE].ctl[CTL_LO];
  assign ctl_now.vsync   = al[CH_BLUE].ctl[CTL_HI];
  assign ctl_now.ctl_one = al[CH_GREEN].ctl[CTL_LO];
  assign ctl_now.ctl_two = al[CH_RED].ctl[CTL_LO];
  assign ctl_now.ctl_three = al[CH_RED].ctl[CTL_HI];

  // ****************************************************************
  // Pixel pairing and output registers
  // ****************************************************************
  slot_t  slot_r;                     // Next pixel is even or odd
  slot_t  slot_nxt;
  pixel_t hold_r;                     // Even pixel waiting for its pair
  pixel_t stg_r;                      // Even pixel delayed by staggering
  logic   stg_pend_r;                 // Staggered even write due
  pixel_t even_r;
  pixel_t odd_r;
  ctrl_bits_t ctl_r;
  logic   de_r;
  logic   pair_done;                  // Odd pixel completes a pair

  assign pair_done = pix2 & de_now & ~de_rise & (slot_r == SLOT_ODD);

  // Slot steps every pixel; a display start forces the even slot
  always_comb begin
    case (slot_r)
      SLOT_EVEN: slot_nxt = SLOT_ODD;
      SLOT_ODD:  slot_nxt = de_rise ? SLOT_ODD : SLOT_EVEN;
      default:   slot_nxt = SLOT_EVEN;
    endcase
  end

  // Stagger trades one pixel of even-bus latency for less ground bounce
  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      slot_r     <= SLOT_EVEN;
      hold_r     <= PIXEL_RST;
      stg_r      <= PIXEL_RST;
      stg_pend_r <= 1'b0;
      even_r     <= PIXEL_RST;
      odd_r      <= PIXEL_RST;
      ctl_r      <= CTRL_RST;
      de_r       <= 1'b0;
      de_prev_r  <= 1'b0;
    end else begin
      slot_r     <= slot_nxt;
      de_prev_r  <= de_now;
      de_r       <= de_now;
      stg_pend_r <= pair_done & ~stagger_select_n_n;
      if (!de_now) begin
        ctl_r <= ctl_now;
      end
      if (!pix2) begin
        odd_r <= PIXEL_RST;
        if (de_now) begin
          even_r <= pix;
        end
      end else if (de_now && (de_rise || slot_r == SLOT_EVEN)) begin
        hold_r <= pix;
      end else if (pair_done) begin
        odd_r <= pix;
        if (stagger_select_n_n) begin
          even_r <= hold_r;
        end else begin
          stg_r <= hold_r;
        end
      end
      if (stg_pend_r) begin
        even_r <= stg_r;
      end
    end
  end

  // Clock mux: the link clock itself, or the odd slot, which is the link clock divided by two
  assign output_pixel_clock_out = pix2 ? (slot_r == SLOT_ODD)
                                       : link_clk_in;
  assign even_pixel_bus_out      = even_r;
  assign odd_pixel_bus_out       = odd_r;
  assign ctrl_bits_out           = ctl_r;
  assign active_display_flag_out = de_r;

  // ****************************************************************
  // Link activity detection on the link clock
  // ****************************************************************
  logic [GAP_W-1:0] gap_r;            // Pixels since last flag change
  logic [RUN_W-1:0] run_r;            // Pixels of renewed activity
  logic             act_r;
  logic             hb_r;             // Heartbeat toggle for the watchdog
  logic             gap_full;
  logic             run_full;

  assign gap_full = (gap_r >= GAP_W'(INACTIVE_PIX - 1));
  assign run_full = (run_r >= RUN_W'(ACTIVE_PIX - 1));

  // Silence restarts on each transition; activity builds while not silent
  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      gap_r <= GAP_W'(INACTIVE_PIX - 1);
      run_r <= '0;
      act_r <= 1'b0;
      hb_r  <= 1'b0;
    end else begin
      hb_r  <= ~hb_r;
      gap_r <= de_tr ? '0 : (gap_full ? gap_r : gap_r + 1'b1);
      if (gap_full && !de_tr) begin
        run_r <= '0;
        act_r <= 1'b0;
      end else begin
        run_r <= run_full ? run_r : run_r + 1'b1;
        act_r <= act_r | run_full;
      end
    end
  end

  // ****************************************************************
  // System domain: activity, watchdog and output enables
  // ****************************************************************
  logic [SYNC_STAGES-1:0] act_s_r;    // Activity level crossing
  logic [SYNC_STAGES:0]   hb_s_r;     // Heartbeat crossing plus history
  logic [SYNC_STAGES-1:0] pdo_s_r;    // Driver powerdown pin sync
  logic [SYNC_STAGES-1:0] pd_s_r;     // Chip powerdown pin sync
  logic [$clog2(STALL_CYC+1)-1:0] stall_r;
  logic                   stalled;
  logic                   lact_r;
  logic                   drv_oe_r;
  logic                   keep_oe_r;

  // A stopped link clock freezes the counter above, so watch it here
  assign stalled = (stall_r == ($bits(stall_r))'(STALL_CYC));

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      act_s_r   <= '0;
      hb_s_r    <= '0;
      pdo_s_r   <= '0;
      pd_s_r    <= '0;
      stall_r   <= '0;
      lact_r    <= 1'b0;
      drv_oe_r  <= 1'b0;
      keep_oe_r <= 1'b0;
    end else begin
      act_s_r   <= {act_s_r[0], act_r};
      hb_s_r    <= {hb_s_r[SYNC_STAGES-1:0], hb_r};
      pdo_s_r   <= {pdo_s_r[0], output_driver_powerdown_n_in};
      pd_s_r    <= {pd_s_r[0], chip_powerdown_n_in};
      if (hb_s_r[SYNC_STAGES] != hb_s_r[SYNC_STAGES-1]) begin
        stall_r <= '0;
      end else if (!stalled) begin
        stall_r <= stall_r + 1'b1;
      end
      lact_r    <= act_s_r[SYNC_STAGES-1] & ~stalled;
      drv_oe_r  <= pd_s_r[SYNC_STAGES-1] & pdo_s_r[SYNC_STAGES-1];
      keep_oe_r <= pd_s_r[SYNC_STAGES-1];
    end
  end

  assign link_active_flag_out = lact_r;
  assign drivers_oe_out       = drv_oe_r;
  assign ctl_one_oe_out       = keep_oe_r;
  assign link_active_oe_out   = keep_oe_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_pair;
    pair_done && stagger_select_n_n;
  endsequence

  sequence s_stagger_select_n_pair;
    pair_done && !stagger_select_n_n;
  endsequence

  property p_ctl_map;
    @(posedge link_clk_in) disable iff (!lrst_n)
    !de_now |=> ctl_r.ctl_one == $past(al[CH_GREEN].ctl[CTL_LO]) &&
                ctl_r.ctl_three == $past(al[CH_RED].ctl[CTL_HI]);
  endproperty
  a_ctl_map: assert property (p_ctl_map)
    else $error("blanking control bits misrouted");

  property p_colour_map;
    @(posedge link_clk_in) disable iff (!lrst_n)
    (!pix2 && de_now) |=> even_r.green == $past(al[CH_GREEN].data) &&
                          even_r.red == $past(al[CH_RED].data);
  endproperty
  a_colour_map: assert property (p_colour_map)
    else $error("colour bytes misrouted");

  property p_de_follow;
    @(posedge link_clk_in) disable iff (!lrst_n)
    de_now |=> de_r ##1 (de_r == $past(de_now));
  endproperty
  a_de_follow: assert property (p_de_follow)
    else $error("display flag does not follow channels");

  property p_odd_low;
    @(posedge link_clk_in) disable iff (!lrst_n)
    !pix2 |=> odd_r == PIXEL_RST;
  endproperty
  a_odd_low: assert property (p_odd_low)
    else $error("odd bus not held low in one-pixel mode");

  property p_simul;
    @(posedge link_clk_in) disable iff (!lrst_n)
    s_pair |=> even_r == $past(hold_r) && odd_r == $past(pix);
  endproperty
  a_simul: assert property (p_simul)
    else $error("pair not presented together");

  property p_stagger;
    @(posedge link_clk_in) disable iff (!lrst_n)
    s_stagger_select_n_pair |=> (even_r == $past(even_r) && odd_r == $past(pix)) ##1
                    even_r == $past(hold_r, 2);
  endproperty
  a_stagger: assert property (p_stagger)
    else $error("staggered even pixel not one pixel late");

  property p_clk_div;
    @(posedge link_clk_in) disable iff (!lrst_n)
    (pix2 && !de_rise) |=> slot_r != $past(slot_r);
  endproperty
  a_clk_div: assert property (p_clk_div)
    else $error("two-pixel output clock not divided by two");

  property p_restart;
    @(posedge link_clk_in) disable iff (!lrst_n)
    de_tr |=> gap_r == '0 ##1 ($past(de_tr) || gap_r == GAP_W'(1));
  endproperty
  a_restart: assert property (p_restart)
    else $error("silence counter not restarted");

  property p_drop;
    @(posedge link_clk_in) disable iff (!lrst_n)
    (gap_full && !de_tr) |=> !act_r && run_r == '0;
  endproperty
  a_drop: assert property (p_drop)
    else $error("link-active kept after long silence");

  property p_oe;
    @(posedge clk_in) disable iff (!reset_n_in)
    !pdo_s_r[SYNC_STAGES-1] |=> !drivers_oe_out ##0
                                (ctl_one_oe_out == $past(pd_s_r[1]));
  endproperty
  a_oe: assert property (p_oe)
    else $error("drivers enabled during driver powerdown");

endmodule : tmds_pixel_out

// [hw/tmds_out_pkg.sv]
// Purpose: Shared types and constants for the receiver pixel output control
// Assumes: Symbols arrive already decoded, one word per channel per pixel
// Notes:   Times are in pixel periods unless a name says _NS
package tmds_out_pkg;

  // ****************************************************************
  // Channel layout
  // ****************************************************************
  localparam int NUM_CH   = 3;        // Data channels on the link
  localparam int CH_BLUE  = 0;        // Blue, sync bits in blanking
  localparam int CH_GREEN = 1;        // Green, control one in blanking
  localparam int CH_RED   = 2;        // Red, controls two/three in blanking
  localparam int CTL_LO   = 0;        // Low control bit of a channel
  localparam int CTL_HI   = 1;        // High control bit of a channel

  // One decoded symbol of a channel
  typedef struct packed {
    logic       is_pixel;             // Pixel character, not control
    logic [1:0] ctl;                  // Control bits carried in blanking
    logic [7:0] data;                 // Colour byte carried in display
  } channel_sym_t;

  // One 24-bit pixel, red in the top byte
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pixel_t;

  // Bits that only travel in blanking
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic ctl_one;
    logic ctl_two;
    logic ctl_three;
  } ctrl_bits_t;

  // Pixel pairing slot in two-pixel mode
  typedef enum logic {
    SLOT_EVEN = 1'b0,
    SLOT_ODD  = 1'b1
  } slot_t;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam pixel_t     PIXEL_RST = 24'h000000;
  localparam ctrl_bits_t CTRL_RST  = 5'h00;
  localparam int ACTIVE_PIX        = 1600;    // Renewed activity to assert
  localparam int INACTIVE_PIX_DEF  = 1000000; // Silence to deassert
  localparam int GAP_W             = 20;      // Silence counter width
  localparam int RUN_W             = 11;      // Activity counter width
  localparam int SYNC_STAGES       = 2;       // Synchroniser depth
  localparam int SYS_CLK_NS        = 20;      // System clock period
  localparam int PIX_MAX_NS        = 40;      // Longest pixel time
  localparam int STALL_PERIODS     = 4;       // Missed link edges tolerated
  localparam int STALL_CYC = STALL_PERIODS *
                 ((PIX_MAX_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

endpackage : tmds_out_pkg

// [hw/channel_deskew.sv]
// Purpose: Aligns the data channels to the latest arriving one
// Assumes: Skew between channels is at most one pixel time
// Notes:   An early channel is delayed from the edge that reveals it on
`timescale 1ns/1ps
module channel_deskew #(
  parameter int NCH = tmds_out_pkg::NUM_CH
) (
  // Clock and reset
  input  wire logic                            clk_in,
  input  wire logic                            reset_n_in,
  // Channel symbols
  input  wire tmds_out_pkg::channel_sym_t [NCH-1:0] sym_in,
  output tmds_out_pkg::channel_sym_t [NCH-1:0]      sym_out
);
  import tmds_out_pkg::*;

  // ****************************************************************
  // Edge detection and delay line
  // ****************************************************************
  channel_sym_t [NCH-1:0] dly_r;      // Previous word of each channel
  channel_sym_t [NCH-1:0] out_r;      // Aligned words
  logic [NCH-1:0]         early_r;    // Channel needs one word of delay
  logic [NCH-1:0]         early_nxt;
  logic [NCH-1:0]         rise;       // Display start seen on channel
  logic                   pend_r;     // Waiting for late channels
  logic                   pend_nxt;
  logic [NCH-1:0]         out_pix;    // Aligned pixel flags, for the check

  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      assign rise[i] = sym_in[i].is_pixel & ~dly_r[i].is_pixel;
      assign out_pix[i] = out_r[i].is_pixel;
      // Early channels read the delayed word
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          dly_r[i] <= '0;
          out_r[i] <= '0;
        end else begin
          dly_r[i] <= sym_in[i];
          // Next delay set, so a cleared skew loses no first pixel
          out_r[i] <= early_nxt[i] ? dly_r[i] : sym_in[i];
        end
      end
    end
  endgenerate

  // A partial set of edges marks the early ones; a full set clears all
  assign early_nxt = (!pend_r && (&rise)) ? '0 :
                     (!pend_r && (|rise)) ? rise : early_r;
  assign pend_nxt  = !pend_r && (|rise) && !(&rise);

  // Skew state
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      early_r <= '0;
      pend_r  <= 1'b0;
    end else begin
      early_r <= early_nxt;
      pend_r  <= pend_nxt;
    end
  end

  assign sym_out = out_r;

  // Late channels must follow within one pixel time
  property p_skew_window;
    @(posedge clk_in) disable iff (!reset_n_in)
    pend_r |=> !pend_r && ((&out_pix) || !(|out_pix));
  endproperty
  a_skew_window: assert property (p_skew_window)
    else $error("late channels not aligned within one pixel time");

endmodule : channel_deskew

// [testbench/link_source_model.sv]
// Purpose: Link transmitter model feeding the receiver output block
// Assumes: Bench hands one word of commands per link edge
// Notes:   Green can be sent one pixel late to exercise deskew
`timescale 1ns/1ps
module link_source_model #(
  parameter int HALF_NS = 16            // Half of the pixel time
) (
  // Commands from the bench
  input  wire logic                     de_in,
  input  wire logic                     skew_in,
  input  wire tmds_out_pkg::pixel_t     pix_in,
  input  wire tmds_out_pkg::ctrl_bits_t ctl_in,
  // Link toward the receiver
  output logic                          link_clk_out,
  output tmds_out_pkg::channel_sym_t [tmds_out_pkg::NUM_CH-1:0] sym_out
);
  import tmds_out_pkg::*;
  // ****************************************************************
  // Word assembly
  // ****************************************************************
  channel_sym_t [NUM_CH-1:0] word_w;   // Aligned word for this pixel
  channel_sym_t              green_r;  // Previous green, for skew
  // Data bytes also travel in blanking so held buses get tested
  assign word_w[CH_BLUE]  = {de_in, ctl_in.vsync, ctl_in.hsync, pix_in.blue};
  // Upper green bit is an ignored extra control, sent as the inverse of control one
  assign word_w[CH_GREEN] = {de_in, ~ctl_in.ctl_one, ctl_in.ctl_one,
                             pix_in.green};
  assign word_w[CH_RED]   = {de_in, ctl_in.ctl_three, ctl_in.ctl_two,
                             pix_in.red};
  // Reference clock runs free at a 32 ns pixel time
  initial begin
    link_clk_out = 1'b0;
    forever begin
      #(HALF_NS) link_clk_out = ~link_clk_out;
    end
  end
  // Launch one word per edge; green may lag one pixel
  always_ff @(posedge link_clk_out) begin
    green_r <= word_w[CH_GREEN];
    sym_out <= word_w;
    sym_out[CH_GREEN] <= skew_in ? green_r : word_w[CH_GREEN];
  end
endmodule : link_source_model

// [testbench/testbench.sv]
// Purpose: Self-checking bench for the pixel output control block
// Assumes: Notes are queued by the sender and popped by a watcher
// Notes:   Silence limit shortened to 2000 pixel times
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  err_count++; $display("Error %s expected %0h seen %0h", n, e, g); \
  end end
module testbench;
  import tmds_out_pkg::*;
  // Expected even and odd pixels, odd updated one edge ahead
  typedef struct packed {pixel_t e; pixel_t o; logic lag;} note_t;
  localparam int QUIET = 2000;           // Shortened silence limit
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic clk_in = 1'b0, reset_n_in = 1'b0;
  logic mode_two = 1'b0, stagger_n = 1'b1;  // Mode pins
  logic drv_pd_n = 1'b1, chip_pd_n = 1'b1;  // Powerdown pins
  logic cmd_de = 1'b0, cmd_skew = 1'b0;     // Link model commands
  pixel_t cmd_pix = '0;
  ctrl_bits_t cmd_ctl = '0;
  logic link_clk, de_w, opc_w, act_w, drv_oe_w, c1_oe_w, act_oe_w;
  channel_sym_t [NUM_CH-1:0] sym;
  pixel_t even_w, odd_w, even_prev, odd_prev, held;
  ctrl_bits_t ctrl_w, ct;
  logic de_prev, have_even = 1'b0;
  note_t nt;
  note_t pq[$];                          // Pixel notes
  ctrl_bits_t cq[$];                     // Control notes
  int err_count = 0, cmp_count = 0;
  link_source_model src (.de_in(cmd_de), .skew_in(cmd_skew),
    .pix_in(cmd_pix), .ctl_in(cmd_ctl), .link_clk_out(link_clk),
    .sym_out(sym));
  tmds_pixel_out #(.INACTIVE_PIX(QUIET)) dut (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .link_clk_in(link_clk), .sym_in(sym),
    .pixels_per_clock_select_in(mode_two), .stagger_select_n_in(stagger_n),
    .output_driver_powerdown_n_in(drv_pd_n), .chip_powerdown_n_in(chip_pd_n),
    .even_pixel_bus_out(even_w), .odd_pixel_bus_out(odd_w),
    .ctrl_bits_out(ctrl_w), .active_display_flag_out(de_w),
    .output_pixel_clock_out(opc_w), .link_active_flag_out(act_w),
    .drivers_oe_out(drv_oe_w), .ctl_one_oe_out(c1_oe_w),
    .link_active_oe_out(act_oe_w));
  // 50 MHz system clock
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic report_and_stop;
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // One word per link edge; pairs are noted once complete
  task automatic send_word(input logic de);
    pixel_t p;
    p = pixel_t'($urandom);
    @(posedge link_clk);
    cmd_de <= de;
    cmd_pix <= p;
    if (de && !mode_two) begin
      pq.push_back({p, PIXEL_RST, 1'b1});
    end else if (de && have_even) begin
      pq.push_back({held, p, !stagger_n});
    end
    held = p;
    have_even = de && !have_even && mode_two;
  endtask : send_word
  // Blanking with fresh control bits, then eight display pixels
  task automatic burst(input logic two, input logic sn, input logic sk);
    ctrl_bits_t c;
    c = ctrl_bits_t'($urandom);
    cq.push_back(c);
    repeat (2) send_word(1'b0);
    cmd_skew <= sk;
    cmd_ctl <= c;
    repeat (2) send_word(1'b0);
    @(posedge clk_in);
    mode_two <= two;
    stagger_n <= sn;
    repeat (2) send_word(1'b0);
    repeat (8) send_word(1'b1);
  endtask : burst
  // Time between two rising edges of the output clock
  task automatic measure(input int exp_ns);
    realtime t0;
    @(posedge opc_w);
    t0 = $realtime;
    @(posedge opc_w);
    `CHK("clock period", exp_ns, int'($realtime - t0))
  endtask : measure
  // ****************************************************************
  // Watcher: a change of the even bus is a result
  // ****************************************************************
  always @(negedge link_clk) begin
    if (reset_n_in && even_w !== even_prev) begin
      nt = (pq.size() > 0) ? pq.pop_front() : '0;
      `CHK("even bus", nt.e, even_w)
      `CHK("odd bus", nt.o, odd_w)
      `CHK("stagger lag", nt.lag, odd_w === odd_prev)
    end
    // Odd bus moves only on a completed pair, inside display
    if (reset_n_in && odd_w !== odd_prev) begin
      `CHK("display flag", 1'b1, de_w)
    end
    // Control bits are judged as display starts
    if (reset_n_in && de_w && !de_prev) begin
      ct = (cq.size() > 0) ? cq.pop_front() : '1;
      `CHK("control bits", ct, ctrl_w)
    end
    even_prev = even_w;
    odd_prev = odd_w;
    de_prev = de_w;
  end
  // Watchdog: the run needs about 140 us
  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(3710));
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge link_clk);
    measure(32);
    // One-pixel, two-pixel simultaneous, then staggered
    for (int b = 0; b < 160; b++) begin
      burst(b >= 60, (b < 60) ? 1'($urandom) : (b < 110), b[3]);
      if (b == 100) begin
        `CHK("link active early", 1'b0, act_w)
      end
      if (b == 130) begin
        `CHK("link active", 1'b1, act_w)
        `CHK("drivers enabled", 1'b1, drv_oe_w)
      end
    end
    // Silence: display flag stops toggling
    fork
      measure(64);
    join_none
    repeat (1950) send_word(1'b0);
    `CHK("link still active", 1'b1, act_w)
    repeat (120) send_word(1'b0);
    repeat (4) @(posedge clk_in);
    `CHK("link inactive", 1'b0, act_w)
    // Board ties link-active to the driver powerdown pin
    drv_pd_n <= act_w;
    repeat (5) @(posedge clk_in);
    `CHK("drivers floated", 1'b0, drv_oe_w)
    `CHK("control one driven", 1'b1, c1_oe_w)
    `CHK("link flag driven", 1'b1, act_oe_w)
    chip_pd_n <= 1'b0;
    repeat (5) @(posedge clk_in);
    `CHK("chip powerdown", 1'b0, c1_oe_w | act_oe_w)
    `CHK("pixel notes left", 0, pq.size())
    `CHK("control notes left", 0, cq.size())
    report_and_stop();
  end
endmodule : testbench
